// ==== include/ds1_line_cfg_pkg.sv ====
// constants, types and reset state for the ds1 line interface config block
// assumes one 20 MHz clock domain and an AXI4-Lite master on the register side
package ds1_line_cfg_pkg;

  localparam int NUM_CH = 4;

  // ****************************************
  // register map
  // ****************************************
  // printed offsets are register indices; byte address is four times the index
  localparam logic [3:0][11:0] IFCFG_IDX  = {12'h400, 12'h300, 12'h200, 12'h100};
  localparam logic [3:0][11:0] CLKCFG_IDX = {12'h401, 12'h301, 12'h201, 12'h101};
  localparam logic [15:0] INT_STATUS_ADDR = 16'h0000;
  localparam logic [15:0] INT_CLEAR_ADDR  = 16'h0004;
  localparam logic [15:0] INT_ENABLE_ADDR = 16'h0008;

  localparam logic [7:0] IFCFG_RST      = 8'h00;
  localparam logic [7:0] CLKCFG_RST     = 8'h00;
  localparam logic [7:0] INT_ENABLE_RST = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RAIL_MODE_BIT              = 7;
  localparam int BIPOLAR_SUBST_ENABLE_BIT   = 6;
  localparam int EXCESS_ZERO_COUNT_EN_BIT   = 5;
  localparam int HIGHWAY_YELLOW_PASS_EN_BIT = 4;
  localparam int FORCE_ONES_DENSITY_BIT     = 3;
  localparam int HIGHWAY_AIS_PASS_EN_BIT    = 2;
  localparam int AUX_IRQ_INPUT_EN_BIT       = 1;
  localparam int AUX_IRQ_INPUT_POLARITY_BIT = 0;
  localparam int TX_CLOCK_EDGE_SELECT_BIT   = 7;
  // slot bit 7 sits one place above the last bit shifted in
  localparam int FORCED_ONE_POS             = 1;
  // status layout: loss of signal in [3:0], excess zeros in [7:4]
  localparam int STATUS_EXZ_BASE            = 4;

  // ****************************************
  // line coding counts
  // ****************************************
  localparam logic [4:0] B8ZS_ZERO_RUN = 5'h08;
  localparam logic [4:0] AMI_ZERO_RUN  = 5'h10;
  localparam logic [4:0] ZERO_RUN_MAX  = 5'h1f;
  localparam logic [2:0] SLOT_LAST_BIT = 3'h7;
  localparam logic [2:0] SUB_V1 = 3'h3;
  localparam logic [2:0] SUB_B1 = 3'h4;
  localparam logic [2:0] SUB_V2 = 3'h6;
  localparam logic [2:0] SUB_B2 = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef struct packed {
    wr_state_t        wrSt;
    logic             awHave;
    logic [15:0]      awAddr;
    logic             wHave;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             bValid;
    logic [1:0]       bResp;
    logic             rValid;
    logic [31:0]      rData;
    logic [1:0]       rResp;
    logic [3:0][7:0]  ifCfg;
    logic [3:0][7:0]  clkCfg;
    logic [7:0]       intStatus;
    logic [7:0]       intEnable;
    logic [3:0]       clkSync1;
    logic [3:0]       clkSync2;
    logic [3:0]       clkPrev;
    logic [3:0]       auxSync1;
    logic [3:0]       auxSync2;
    logic [3:0][7:0]  txSr;
    logic [3:0][2:0]  bitCnt;
    logic [3:0]       lastPol;
    logic [3:0][2:0]  subPos;
    logic [3:0]       subAct;
    logic [3:0]       posRail;
    logic [3:0]       negRail;
    logic [3:0]       nrzData;
    logic [3:0]       lineMode;
    logic [3:0]       sendYellow;
    logic [3:0]       sendAis;
    logic [3:0][4:0]  zeroRun;
    logic [3:0]       bpvInc;
    logic [3:0]       losEvt;
    logic             refA;
    logic             refB;
  } state_t;

  localparam state_t STATE_RST = '{
    wrSt:      WR_IDLE,
    ifCfg:     {4{IFCFG_RST}},
    clkCfg:    {4{CLKCFG_RST}},
    intEnable: INT_ENABLE_RST,
    default:   '0
  };

  function automatic logic [15:0] byte_addr(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

endpackage

// ==== rtl/ds1_line_interface_config.sv ====
// line-side configuration, line coding and alarm pass-through for four ds1 channels
// assumes an AXI4-Lite master on sys_clk; link clocks and aux interrupt pins are
// asynchronous and are sampled here; all other inputs come from sys_clk logic
//
// The implementer's own choice: the AXI4-Lite slave port.

module ds1_line_interface_config
  import ds1_line_cfg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output wire logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output wire logic        wready,
  output wire logic [1:0]  bresp,
  output wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output wire logic        arready,
  output wire logic [31:0] rdata,
  output wire logic [1:0]  rresp,
  output wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic [3:0]  lineTxClock,
  input  wire logic [3:0]  txData,
  input  wire logic [3:0]  txSlotSync,
  input  wire logic [3:0]  txModeEn,
  input  wire logic [3:0]  fastSync,
  input  wire logic [3:0]  highwayYellow,
  input  wire logic [3:0]  highwayAis,
  input  wire logic [3:0]  rxBit,
  input  wire logic [3:0]  rxBitValid,
  input  wire logic [3:0]  rxCodeViolation,
  input  wire logic [3:0]  lossOfSignal,
  input  wire logic [3:0]  auxIrqInputPin,
  input  wire logic        clockRefInA,
  input  wire logic        clockRefInB,
  output wire logic [3:0]  posRail,
  output wire logic [3:0]  negRail,
  output wire logic [3:0]  nrzData,
  output wire logic [3:0]  lineModeOutput,
  output wire logic [3:0]  sendYellow,
  output wire logic [3:0]  sendAis,
  output wire logic [3:0]  bpvCountInc,
  output wire logic [3:0]  losEvent,
  output wire logic        clockRefOutA,
  output wire logic        clockRefOutB,
  output wire logic        irq
);

  state_t     s;
  state_t     next_s;
  logic [3:0] txEdge;
  logic [3:0] auxAct;
  logic [3:0] auxHold;
  logic       wrFire;

  // ****************************************
  // per channel edge and aux level decode
  // ****************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    // rising edges when set, falling edges when clear
    assign txEdge[g] = s.clkCfg[g][TX_CLOCK_EDGE_SELECT_BIT] ?
                       (s.clkSync2[g] & ~s.clkPrev[g]) : (~s.clkSync2[g] & s.clkPrev[g]);
    // polarity 1 means a low pin is active
    assign auxAct[g]  = s.auxSync2[g] ^ s.ifCfg[g][AUX_IRQ_INPUT_POLARITY_BIT];
    assign auxHold[g] = auxAct[g] & s.ifCfg[g][AUX_IRQ_INPUT_EN_BIT];
  end

  assign wrFire  = (s.wrSt == WR_IDLE) && s.awHave && s.wHave;
  assign awready = (s.wrSt == WR_IDLE) && !s.awHave;
  assign wready  = (s.wrSt == WR_IDLE) && !s.wHave;
  assign arready = !s.rValid;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0] sr;
    logic [7:0] setBits;
    logic [7:0] clrBits;
    logic [2:0] pos;
    logic [4:0] thr;
    logic       pol;
    logic       pulse;
    logic       exz;
    next_s  = s;
    sr      = '0;
    setBits = '0;
    clrBits = '0;
    pos     = '0;
    thr     = '0;
    pol     = 1'b0;
    pulse   = 1'b0;
    exz     = 1'b0;

    next_s.clkSync1 = lineTxClock;
    next_s.clkSync2 = s.clkSync1;
    next_s.clkPrev  = s.clkSync2;
    next_s.auxSync1 = auxIrqInputPin;
    next_s.auxSync2 = s.auxSync1;

    // address and data may arrive in either order
    if (awvalid && awready) begin
      next_s.awHave = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.wHave = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (wrFire) begin
      next_s.bResp = RESP_SLVERR;
      for (int i = 0; i < NUM_CH; i++) begin
        if (s.awAddr == byte_addr(IFCFG_IDX[i])) begin
          next_s.bResp = RESP_OKAY;
          if (s.wStrb[0]) next_s.ifCfg[i] = s.wData[7:0];
        end
        if (s.awAddr == byte_addr(CLKCFG_IDX[i])) begin
          next_s.bResp = RESP_OKAY;
          if (s.wStrb[0]) next_s.clkCfg[i] = s.wData[7:0];
        end
      end
      if (s.awAddr == INT_STATUS_ADDR) next_s.bResp = RESP_OKAY;
      if (s.awAddr == INT_CLEAR_ADDR) begin
        next_s.bResp = RESP_OKAY;
        if (s.wStrb[0]) clrBits = s.wData[7:0];
      end
      if (s.awAddr == INT_ENABLE_ADDR) begin
        next_s.bResp = RESP_OKAY;
        if (s.wStrb[0]) next_s.intEnable = s.wData[7:0];
      end
      next_s.awHave = 1'b0;
      next_s.wHave  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.wrSt   = WR_RESP;
    end
    case (s.wrSt)
      WR_IDLE: ;
      WR_RESP: begin
        if (bready) begin
          next_s.bValid = 1'b0;
          next_s.wrSt   = WR_IDLE;
        end
      end
      default: next_s.wrSt = WR_IDLE;
    endcase

    if (s.rValid && rready) next_s.rValid = 1'b0;
    if (arvalid && arready) begin
      next_s.rValid = 1'b1;
      next_s.rData  = '0;
      next_s.rResp  = RESP_SLVERR;
      for (int i = 0; i < NUM_CH; i++) begin
        if (araddr == byte_addr(IFCFG_IDX[i])) begin
          next_s.rData = {24'h000000, s.ifCfg[i]};
          next_s.rResp = RESP_OKAY;
        end
        if (araddr == byte_addr(CLKCFG_IDX[i])) begin
          next_s.rData = {24'h000000, s.clkCfg[i]};
          next_s.rResp = RESP_OKAY;
        end
      end
      if (araddr == INT_STATUS_ADDR) begin
        next_s.rData = {24'h000000, s.intStatus};
        next_s.rResp = RESP_OKAY;
      end
      // clear register is write-only and reads as zero
      if (araddr == INT_CLEAR_ADDR) next_s.rResp = RESP_OKAY;
      if (araddr == INT_ENABLE_ADDR) begin
        next_s.rData = {24'h000000, s.intEnable};
        next_s.rResp = RESP_OKAY;
      end
    end

    for (int i = 0; i < NUM_CH; i++) begin
      // ****************************************
      // transmit path
      // ****************************************
      next_s.sendYellow[i] = txModeEn[i] & highwayYellow[i]
                           & s.ifCfg[i][HIGHWAY_YELLOW_PASS_EN_BIT];
      next_s.sendAis[i]    = txModeEn[i] & highwayAis[i]
                           & s.ifCfg[i][HIGHWAY_AIS_PASS_EN_BIT];
      next_s.lineMode[i]   = !s.ifCfg[i][RAIL_MODE_BIT] & !fastSync[i]
                           & s.ifCfg[i][BIPOLAR_SUBST_ENABLE_BIT];
      if (txEdge[i]) begin
        pos              = txSlotSync[i] ? 3'h0 : s.bitCnt[i];
        next_s.bitCnt[i] = pos + 3'h1;
        // ais replaces payload with all ones ahead of the coder
        sr = {s.txSr[i][6:0], s.sendAis[i] | txData[i]};
        if (pos == SLOT_LAST_BIT && sr == 8'h00 && s.ifCfg[i][FORCE_ONES_DENSITY_BIT]
            && !s.ifCfg[i][BIPOLAR_SUBST_ENABLE_BIT]) begin
          sr[FORCED_ONE_POS] = 1'b1;
        end
        next_s.txSr[i]    = sr;
        next_s.nrzData[i] = s.txSr[i][7];
        pulse = 1'b0;
        pol   = 1'b0;
        if (s.ifCfg[i][RAIL_MODE_BIT]) begin
          // eight-bit delay line gives the lookahead that substitution needs
          if (s.subAct[i]) begin
            next_s.subPos[i] = s.subPos[i] + 3'h1;
            next_s.subAct[i] = s.subPos[i] != SUB_B2;
            case (s.subPos[i])
              SUB_V1, SUB_V2: begin
                pulse = 1'b1;
                pol   = s.lastPol[i];
              end
              SUB_B1, SUB_B2: begin
                pulse = 1'b1;
                pol   = !s.lastPol[i];
              end
              default: pulse = 1'b0;
            endcase
          end else if (s.ifCfg[i][BIPOLAR_SUBST_ENABLE_BIT] && s.txSr[i] == 8'h00) begin
            next_s.subAct[i] = 1'b1;
            next_s.subPos[i] = 3'h1;
          end else if (s.txSr[i][7]) begin
            pulse = 1'b1;
            pol   = !s.lastPol[i];
          end
          // violations repeat the last polarity and leave it unchanged
          if (pulse && pol != s.lastPol[i]) next_s.lastPol[i] = pol;
        end
        next_s.posRail[i] = pulse & pol;
        next_s.negRail[i] = pulse & !pol;
      end

      // ****************************************
      // receive excess zeros
      // ****************************************
      thr = s.ifCfg[i][BIPOLAR_SUBST_ENABLE_BIT] ? B8ZS_ZERO_RUN : AMI_ZERO_RUN;
      exz = 1'b0;
      next_s.bpvInc[i] = 1'b0;
      if (rxBitValid[i]) begin
        if (rxBit[i]) next_s.zeroRun[i] = '0;
        else if (s.zeroRun[i] != ZERO_RUN_MAX) next_s.zeroRun[i] = s.zeroRun[i] + 5'h01;
        // one hit per run: the count passes the threshold once
        exz = s.ifCfg[i][EXCESS_ZERO_COUNT_EN_BIT] & !rxBit[i]
            & (s.zeroRun[i] + 5'h01 == thr);
        next_s.bpvInc[i] = rxCodeViolation[i] | exz;
      end

      next_s.losEvt[i] = lossOfSignal[i] | auxHold[i];
      setBits[i] = next_s.losEvt[i];
      setBits[STATUS_EXZ_BASE + i] = exz;
    end

    // set beats a clear landing in the same cycle
    next_s.intStatus = (s.intStatus & ~clrBits) | setBits;
    next_s.refA = clockRefInA & !(|auxHold);
    next_s.refB = clockRefInB & !(|auxHold);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) s <= STATE_RST;
    else s <= next_s;
  end

  assign bresp          = s.bResp;
  assign bvalid         = s.bValid;
  assign rdata          = s.rData;
  assign rresp          = s.rResp;
  assign rvalid         = s.rValid;
  assign posRail        = s.posRail;
  assign negRail        = s.negRail;
  assign nrzData        = s.nrzData;
  assign lineModeOutput = s.lineMode;
  assign sendYellow     = s.sendYellow;
  assign sendAis        = s.sendAis;
  assign bpvCountInc    = s.bpvInc;
  assign losEvent       = s.losEvt;
  assign clockRefOutA   = s.refA;
  assign clockRefOutB   = s.refB;
  assign irq            = |(s.intStatus & s.intEnable);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_chk
    sequence s_sub_start;
      txEdge[g] && s.ifCfg[g][RAIL_MODE_BIT] && s.ifCfg[g][BIPOLAR_SUBST_ENABLE_BIT]
        && !s.subAct[g] && s.txSr[g] == 8'h00;
    endsequence
    sequence s_run_hit;
      rxBitValid[g] && !rxBit[g] && s.ifCfg[g][EXCESS_ZERO_COUNT_EN_BIT]
        && (s.zeroRun[g] + 5'h01 == (s.ifCfg[g][BIPOLAR_SUBST_ENABLE_BIT] ?
            B8ZS_ZERO_RUN : AMI_ZERO_RUN));
    endsequence

    property p_nrz_quiet;
      txEdge[g] && !s.ifCfg[g][RAIL_MODE_BIT] |=>
        !posRail[g] && !negRail[g] && nrzData[g] == $past(s.txSr[g][7]);
    endproperty
    a_nrz_quiet: assert property (p_nrz_quiet) else $error("rails active in nrz");

    property p_ami_alt;
      txEdge[g] && s.ifCfg[g][RAIL_MODE_BIT] && !s.subAct[g] && s.txSr[g][7] |=>
        posRail[g] == !$past(s.lastPol[g]) && negRail[g] == $past(s.lastPol[g]);
    endproperty
    a_ami_alt: assert property (p_ami_alt) else $error("mark polarity wrong");

    property p_sub_start;
      s_sub_start |=> s.subAct[g] && !posRail[g] && !negRail[g] && s.subPos[g] == 3'h1;
    endproperty
    a_sub_start: assert property (p_sub_start) else $error("b8zs not started");

    property p_line_mode;
      1'b1 |=> lineModeOutput[g] == $past(!s.ifCfg[g][RAIL_MODE_BIT] && !fastSync[g]
        && s.ifCfg[g][BIPOLAR_SUBST_ENABLE_BIT]);
    endproperty
    a_line_mode: assert property (p_line_mode) else $error("line mode pin wrong");

    property p_exz_off;
      rxBitValid[g] && !rxBit[g] && !rxCodeViolation[g]
        && !s.ifCfg[g][EXCESS_ZERO_COUNT_EN_BIT] |=> !bpvCountInc[g];
    endproperty
    a_exz_off: assert property (p_exz_off) else $error("zeros counted when off");

    property p_exz_hit;
      s_run_hit |=> bpvCountInc[g] && s.intStatus[STATUS_EXZ_BASE + g];
    endproperty
    a_exz_hit: assert property (p_exz_hit) else $error("zero run missed");

    property p_yellow;
      1'b1 |=> sendYellow[g] == $past(txModeEn[g] && highwayYellow[g]
        && s.ifCfg[g][HIGHWAY_YELLOW_PASS_EN_BIT]);
    endproperty
    a_yellow: assert property (p_yellow) else $error("yellow pass wrong");

    property p_fod;
      txEdge[g] && !txSlotSync[g] && s.bitCnt[g] == SLOT_LAST_BIT && s.txSr[g][6:0] == 7'h00
        && !(s.sendAis[g] | txData[g]) && s.ifCfg[g][FORCE_ONES_DENSITY_BIT]
        && !s.ifCfg[g][BIPOLAR_SUBST_ENABLE_BIT] |=> s.txSr[g] == 8'h02;
    endproperty
    a_fod: assert property (p_fod) else $error("ones density not forced");

    property p_ais;
      txModeEn[g] && highwayAis[g] && s.ifCfg[g][HIGHWAY_AIS_PASS_EN_BIT] |=> sendAis[g];
    endproperty
    a_ais: assert property (p_ais) else $error("ais not passed");

    property p_los;
      1'b1 |=> losEvent[g] == $past(lossOfSignal[g] || (s.ifCfg[g][AUX_IRQ_INPUT_EN_BIT]
        && (s.auxSync2[g] ^ s.ifCfg[g][AUX_IRQ_INPUT_POLARITY_BIT])));
    endproperty
    a_los: assert property (p_los) else $error("los merge wrong");

    property p_edge;
      !txEdge[g] |=> $stable(s.txSr[g]) && $stable(posRail[g]);
    endproperty
    a_edge: assert property (p_edge) else $error("tx moved off edge");
  end

  property p_ref_hold;
    |auxHold |=> !clockRefOutA && !clockRefOutB;
  endproperty
  a_ref_hold: assert property (p_ref_hold) else $error("clock ref not held");

  property p_cfg_write;
    wrFire && s.awAddr == byte_addr(IFCFG_IDX[0]) && s.wStrb[0] |=>
      s.ifCfg[0] == $past(s.wData[7:0]) && bvalid && bresp == RESP_OKAY;
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

endmodule

// ==== tb/line_unit_model.sv ====
// line unit model: transmit clock source, receive bit source, line mark counters
// assumes the config block's rail and count outputs are in the sys_clk domain
module line_unit_model (
  input  wire logic       sys_clk,
  input  wire logic       run,
  input  wire logic [3:0] posRail,
  input  wire logic [3:0] negRail,
  input  wire logic [3:0] bpvCountInc,
  output var  logic [3:0] lineTxClock,
  output var  logic [3:0] rxBit,
  output var  logic [3:0] rxBitValid,
  output var  logic [3:0] rxCodeViolation
);
  timeunit 1ns;
  timeprecision 1ps;
  int   posCnt;
  int   negCnt;
  int   bothCnt;
  int   bpvCnt;
  logic posPrev;
  logic negPrev;

  // free phase against sys_clk; stands still while run is low
  initial begin
    lineTxClock = 4'h0;
    rxBit = 4'h0;
    rxBitValid = 4'h0;
    rxCodeViolation = 4'h0;
    posPrev = 1'b0;
    negPrev = 1'b0;
    #13;
    forever begin
      #200;
      if (run) lineTxClock = ~lineTxClock;
    end
  end

  always @(posedge sys_clk) begin
    posPrev <= posRail[0];
    negPrev <= negRail[0];
    if (posRail[0] && !posPrev) posCnt <= posCnt + 1;
    if (negRail[0] && !negPrev) negCnt <= negCnt + 1;
    if (posRail[0] && negRail[0]) bothCnt <= bothCnt + 1;
    if (bpvCountInc[0]) bpvCnt <= bpvCnt + 1;
  end

  task automatic clear_counts();
    posCnt = 0;
    negCnt = 0;
    bothCnt = 0;
  endtask

  // released lines show the inverse, not the last value
  task automatic send_rx(input logic b, input logic cv);
    @(posedge sys_clk);
    rxBit <= {4{b}};
    rxCodeViolation <= {4{cv}};
    rxBitValid <= 4'hf;
    @(posedge sys_clk);
    rxBitValid <= 4'h0;
    rxBit <= ~{4{b}};
    rxCodeViolation <= ~{4{cv}};
  endtask
endmodule

// ==== tb/tb_ds1_line_interface_config.sv ====
// testbench for the ds1 line interface config block over AXI4-Lite
// assumes the line unit model on the far side; channel 0 carries line traffic
module tb_ds1_line_interface_config import ds1_line_cfg_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, run;
  logic        awready, wready, bvalid, arready, rvalid, irq, refOutA, refOutB;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, txData, txModeEn, yel, ais, losIn, auxPin, txClk, fs;
  logic [3:0]  rxBit, rxBitValid, rxCv, posRail, negRail, nrzData, lineMode;
  logic [3:0]  sendYellow, sendAis, bpvInc, losEvent;
  logic [1:0]  bresp, rresp, rs;
  int          error_cnt, tests_run, ch, i;

  ds1_line_interface_config u_ds1_line_interface_config (.sys_clk(sys_clk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .lineTxClock(txClk), .txData(txData),
    .txSlotSync(4'h0), .txModeEn(txModeEn), .fastSync(fs), .highwayYellow(yel),
    .highwayAis(ais), .rxBit(rxBit), .rxBitValid(rxBitValid), .rxCodeViolation(rxCv),
    .lossOfSignal(losIn), .auxIrqInputPin(auxPin), .clockRefInA(1'b1), .clockRefInB(1'b1),
    .posRail(posRail), .negRail(negRail), .nrzData(nrzData), .lineModeOutput(lineMode),
    .sendYellow(sendYellow), .sendAis(sendAis), .bpvCountInc(bpvInc), .losEvent(losEvent),
    .clockRefOutA(refOutA), .clockRefOutB(refOutB), .irq(irq));

  line_unit_model u_line_unit_model (.sys_clk(sys_clk), .run(run), .posRail(posRail),
    .negRail(negRail), .bpvCountInc(bpvInc), .lineTxClock(txClk), .rxBit(rxBit),
    .rxBitValid(rxBitValid), .rxCodeViolation(rxCv));

  // ****
  // bus tasks
  // ****
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ready and answers sampled at the falling edge, the handshake lands on the next rise
  // bready and rready stay high all run: back-to-back calls never re-drive them
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw, got;
    int   n;
    pa = 1; pw = 1; got = 0;
    awaddr <= a; wdata <= d; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(negedge sys_clk);
      ta = pa && awready;
      tw = pw && wready;
      got = !pa && !pw && bvalid;
      r = bresp;
      @(posedge sys_clk);
      if (ta) begin awvalid <= 1'b0; pa = 0; end
      if (tw) begin wvalid <= 1'b0; pw = 0; end
    end
    if (!got) begin check("write handshake", 1, 0); finish_test(); end
  endtask

  task automatic axi_read(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, ta, got;
    int   n;
    pa = 1; got = 0;
    araddr <= a; arvalid <= 1'b1;
    for (n = 0; n < 50 && !got; n++) begin
      @(negedge sys_clk);
      ta = pa && arready;
      got = !pa && rvalid;
      d = rdata;
      r = rresp;
      @(posedge sys_clk);
      if (ta) begin arvalid <= 1'b0; pa = 0; end
    end
    if (!got) begin check("read handshake", 1, 0); finish_test(); end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    axi_write(a, d, rs);
    check("write response", RESP_OKAY, rs);
  endtask

  task automatic rdchk(input string name, input logic [15:0] a, input logic [31:0] exp);
    axi_read(a, rd, rs);
    check(name, exp, rd);
    check("read response", RESP_OKAY, rs);
  endtask

  function automatic logic [15:0] cfg_addr(input int c, input int sel);
    return 16'((c + 1) * 1024 + sel * 4);
  endfunction

  task automatic zeros(input int n);
    repeat (n) u_line_unit_model.send_rx(1'b0, 1'b0);
    repeat (2) @(posedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ****
  // scenarios
  // ****
  initial begin
    rst_n = 0; awvalid = 0; wvalid = 0; bready = 1; arvalid = 0; rready = 1; run = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; txData = 0; txModeEn = 0;
    yel = 0; ais = 0; losIn = 0; auxPin = 0; fs = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (ch = 0; ch < 4; ch++) begin
      rdchk("line cfg reset", cfg_addr(ch, 0), 32'h0);
      rdchk("clock cfg reset", cfg_addr(ch, 1), 32'h0);
      wr(cfg_addr(ch, 0), 32'h58 + ch);
      wr(cfg_addr(ch, 1), 32'h80 + ch);
      rdchk("line cfg", cfg_addr(ch, 0), 32'h58 + ch);
      rdchk("clock cfg", cfg_addr(ch, 1), 32'h80 + ch);
      wr(cfg_addr(ch, 0), 32'h0);
    end
    axi_read(16'h0ffc, rd, rs);
    check("unmapped read", RESP_SLVERR, rs);
    axi_write(16'h0ffc, 32'h1, rs);
    check("unmapped write", RESP_SLVERR, rs);
    wr(cfg_addr(0, 0), 32'h40);
    repeat (2) @(posedge sys_clk);
    check("line mode nrz", 1, lineMode[0]);
    fs <= 4'hf;
    repeat (2) @(posedge sys_clk);
    check("line mode fast sync", 0, lineMode[0]);
    fs <= 4'h0;
    wr(cfg_addr(0, 0), 32'hc0);
    repeat (2) @(posedge sys_clk);
    check("line mode rail", 0, lineMode[0]);
    // both tx edges, nrz follows the payload after the eight-bit delay
    run <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wr(cfg_addr(0, 1), i ? 32'h00 : 32'h80);
      wr(cfg_addr(0, 0), 32'h0);
      txData <= 4'hf;
      repeat (100) @(posedge sys_clk);
      check("nrz ones", 1, nrzData[0]);
      txData <= 4'h0;
      repeat (100) @(posedge sys_clk);
      check("nrz zeros", 0, nrzData[0]);
    end
    wr(cfg_addr(0, 0), 32'h80);
    txData <= 4'hf;
    repeat (100) @(posedge sys_clk);
    u_line_unit_model.clear_counts();
    repeat (100) @(posedge sys_clk);
    check("ami positive marks", 1, u_line_unit_model.posCnt > 0);
    check("ami negative marks", 1, u_line_unit_model.negCnt > 0);
    check("rails together", 0, u_line_unit_model.bothCnt);
    // third pass: ami with forced ones density puts marks into all-zero slots
    for (i = 0; i < 3; i++) begin
      wr(cfg_addr(0, 0), (i == 2) ? 32'h88 : (i ? 32'hc0 : 32'h80));
      txData <= 4'h0;
      repeat (100) @(posedge sys_clk);
      u_line_unit_model.clear_counts();
      repeat (100) @(posedge sys_clk);
      check("zero run marks", i > 0,
            (u_line_unit_model.posCnt + u_line_unit_model.negCnt) > 0);
    end
    run <= 1'b0;
    // alarm pass-through: set, disabled, outside transmission mode
    yel <= 4'hf;
    ais <= 4'hf;
    for (i = 0; i < 3; i++) begin
      txModeEn <= (i == 2) ? 4'h0 : 4'hf;
      wr(cfg_addr(0, 0), (i == 1) ? 32'h00 : 32'h14);
      repeat (3) @(posedge sys_clk);
      check("yellow to line", i == 0, sendYellow[0]);
      check("ais to line", i == 0, sendAis[0]);
    end
    // earlier config writes with aux enabled can leave sticky loss events behind
    wr(INT_CLEAR_ADDR, 32'hff);
    wr(INT_ENABLE_ADDR, 32'h1);
    rdchk("enable", INT_ENABLE_ADDR, 32'h1);
    wr(cfg_addr(0, 0), 32'h02);
    for (i = 0; i < 4; i++) begin
      if (i == 2) wr(cfg_addr(0, 0), 32'h03);
      auxPin <= {3'h0, i[0]};
      repeat (5) @(posedge sys_clk);
      check("aux to los", i == 1 || i == 2, losEvent[0]);
      check("clock ref gate", !(i == 1 || i == 2), refOutA);
      check("clock ref b gate", !(i == 1 || i == 2), refOutB);
    end
    check("irq raised", 1, irq);
    wr(cfg_addr(0, 0), 32'h00);
    losIn <= 4'h1;
    repeat (3) @(posedge sys_clk);
    check("internal los", 1, losEvent[0]);
    losIn <= 4'h0;
    repeat (3) @(posedge sys_clk);
    check("aux disabled", 0, losEvent[0]);
    rdchk("status sticky", INT_STATUS_ADDR, 32'h1);
    wr(INT_ENABLE_ADDR, 32'h0);
    check("irq masked", 0, irq);
    wr(INT_ENABLE_ADDR, 32'h1);
    check("irq unmasked", 1, irq);
    wr(INT_CLEAR_ADDR, 32'hff);
    rdchk("status cleared", INT_STATUS_ADDR, 32'h0);
    check("irq cleared", 0, irq);
    // excess zeros: one error per run, threshold by coding
    u_line_unit_model.bpvCnt = 0;
    wr(cfg_addr(0, 0), 32'he0);
    zeros(20);
    check("b8zs run", 1, u_line_unit_model.bpvCnt);
    u_line_unit_model.send_rx(1'b1, 1'b0);
    wr(cfg_addr(0, 0), 32'ha0);
    zeros(15);
    check("ami short run", 1, u_line_unit_model.bpvCnt);
    zeros(6);
    check("ami run", 2, u_line_unit_model.bpvCnt);
    wr(cfg_addr(0, 0), 32'hc0);
    u_line_unit_model.send_rx(1'b1, 1'b0);
    zeros(20);
    check("zero count off", 2, u_line_unit_model.bpvCnt);
    u_line_unit_model.send_rx(1'b1, 1'b1);
    zeros(0);
    check("code violation", 3, u_line_unit_model.bpvCnt);
    finish_test();
  end
endmodule
